// ===== design/xlu_pkg.sv
// Package with constants and types for the exclusive-OR logic unit
//
// Summary of operation
// - The register form XORs the source operand into the destination general register.
// - The register form writes only a general register; its source may use any mode.
// - The register form sets N when the result is negative and Z when it is zero.
// - The register form clears V, keeps C, and works on bytes or words.
// - The control form XORs immediate data into the selected control register.
// - On the status word or flag byte, N, Z, V and C become the result's own bits.
// - On a page or base register, N is the result MSB, Z flags zero, V clears, C holds.
// - The control form is word-sized for the status word and byte-sized otherwise.
// - No interrupt or trace is taken at the boundary right after a control form.
// - The control form is an immediate prefix, its data bytes, then 01101 and a selector.
// - The size bit of the effective-address byte means byte when 0 and word when 1.
// - Selector 000 is the status word, 011 base, 100 extended, 101 data, 111 stack page.
// - The general register field picks R0 to R7 by its binary value.
package xlu_pkg;

    // ------------------------------------------------------------
    // Instruction encodings
    // ------------------------------------------------------------
    localparam logic [3:0] XLU_EA_RN = 4'hA;
    localparam logic [3:0] XLU_EA_IND = 4'hD;
    localparam logic [3:0] XLU_EA_D8 = 4'hE;
    localparam logic [3:0] XLU_EA_D16 = 4'hF;
    localparam logic [3:0] XLU_EA_PREDEC = 4'hB;
    localparam logic [3:0] XLU_EA_POSTINC = 4'hC;
    localparam logic [3:0] XLU_EA_AA8 = 4'h0;
    localparam logic [3:0] XLU_EA_AA16 = 4'h1;
    localparam logic [2:0] XLU_EA_ABS_LOW = 3'h5;
    localparam logic [7:0] XLU_PFX_IMM8 = 8'h04;
    localparam logic [7:0] XLU_PFX_IMM16 = 8'h0C;
    localparam int XLU_SIZE_BIT = 3;
    localparam logic [4:0] XLU_OP_XOR = 5'h0C;
    localparam logic [4:0] XLU_OP_CTRL = 5'h0D;

    // ------------------------------------------------------------
    // Control register selectors
    // ------------------------------------------------------------
    localparam logic [2:0] XLU_SEL_STATUS = 3'h0;
    localparam logic [2:0] XLU_SEL_FLAGS = 3'h1;
    localparam logic [2:0] XLU_SEL_BASE = 3'h3;
    localparam logic [2:0] XLU_SEL_EXT = 3'h4;
    localparam logic [2:0] XLU_SEL_DATA = 3'h5;
    localparam logic [2:0] XLU_SEL_STACK = 3'h7;

    // ------------------------------------------------------------
    // Flag positions and reset values
    // ------------------------------------------------------------
    localparam int XLU_FLAG_N = 3;
    localparam int XLU_FLAG_Z = 2;
    localparam int XLU_FLAG_V = 1;
    localparam int XLU_FLAG_C = 0;
    localparam logic [15:0] XLU_RST_WORD = 16'h0000;
    localparam logic [7:0] XLU_RST_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Register map (word index on the plain port)
    // ------------------------------------------------------------
    localparam logic [3:0] XLU_ADR_GR0 = 4'h0;
    localparam logic [3:0] XLU_ADR_STATUS = 4'h8;
    localparam logic [3:0] XLU_ADR_BASE = 4'h9;
    localparam logic [3:0] XLU_ADR_EXT = 4'hA;
    localparam logic [3:0] XLU_ADR_DATA = 4'hB;
    localparam logic [3:0] XLU_ADR_STACK = 4'hC;
    localparam logic [3:0] XLU_ADR_UNIT = 4'hD;
    localparam int XLU_UNIT_RESYNC = 0;
    localparam int XLU_UNIT_INHIBIT = 4;
    localparam int XLU_UNIT_ILLEGAL = 5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        XLU_ST_EA = 4'b0001,
        XLU_ST_EXT_H = 4'b0010,
        XLU_ST_EXT_L = 4'b0100,
        XLU_ST_OP = 4'b1000
    } xlu_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } xlu_bus_s;

    typedef struct packed {
        logic word;
        logic src_reg;
        logic src_imm;
        logic [2:0] rsel;
        logic [15:0] imm;
    } xlu_insn_s;

endpackage

// ===== design/xlu_top.sv
// Exclusive-OR execution unit: byte decoder, register file and flag update
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps

module xlu_top (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic [15:0] operand_i,
    input wire xlu_pkg::xlu_bus_s bus_i,
    output logic [15:0] rd_data_o,
    output logic done_o,
    output logic illegal_o,
    output logic int_inhibit_o,
    output logic trace_inhibit_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    xlu_pkg::xlu_state_e state;
    xlu_pkg::xlu_state_e next_state;
    xlu_pkg::xlu_insn_s insn;
    xlu_pkg::xlu_insn_s next_insn;
    logic [15:0] gr [8];
    logic [15:0] next_gr [8];
    logic [15:0] status_word;
    logic [15:0] next_status_word;
    logic [7:0] base_reg;
    logic [7:0] next_base_reg;
    logic [7:0] extended_page_reg;
    logic [7:0] next_extended_page_reg;
    logic [7:0] data_page_reg;
    logic [7:0] next_data_page_reg;
    logic [7:0] stack_page_reg;
    logic [7:0] next_stack_page_reg;
    logic illegal_seen;
    logic next_illegal_seen;
    logic [15:0] next_rd_data;
    logic next_done;
    logic next_illegal;
    logic next_inhibit;

    // Opcode byte strobes and the register-port resync strobe
    logic op_cycle;
    logic is_xor;
    logic is_ctrl;
    logic resync;

    assign op_cycle = byte_valid_i && (state == xlu_pkg::XLU_ST_OP);
    assign is_xor = op_cycle && (byte_i[7:3] == xlu_pkg::XLU_OP_XOR);
    assign is_ctrl = op_cycle && (byte_i[7:3] == xlu_pkg::XLU_OP_CTRL);
    assign resync = bus_i.wr && (bus_i.addr == xlu_pkg::XLU_ADR_UNIT)
        && bus_i.wdata[xlu_pkg::XLU_UNIT_RESYNC];

    // ------------------------------------------------------------
    // Instruction byte decoder
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_insn = insn;
        if (resync) begin
            next_state = xlu_pkg::XLU_ST_EA;
        end else if (byte_valid_i) begin
            unique case (state)
                xlu_pkg::XLU_ST_EA: begin
                    next_insn.word = byte_i[xlu_pkg::XLU_SIZE_BIT];
                    next_insn.rsel = byte_i[2:0];
                    next_insn.src_reg = 1'b0;
                    next_insn.src_imm = 1'b0;
                    next_insn.imm = 16'h0000;
                    // Memory-mode extension bytes go unused; memory operands arrive on operand_i
                    if (byte_i == xlu_pkg::XLU_PFX_IMM8) begin
                        next_insn.src_imm = 1'b1;
                        next_insn.word = 1'b0;
                        next_state = xlu_pkg::XLU_ST_EXT_L;
                    end else if (byte_i == xlu_pkg::XLU_PFX_IMM16) begin
                        next_insn.src_imm = 1'b1;
                        next_insn.word = 1'b1;
                        next_state = xlu_pkg::XLU_ST_EXT_H;
                    end else if (byte_i[7:4] == xlu_pkg::XLU_EA_RN) begin
                        next_insn.src_reg = 1'b1;
                        next_state = xlu_pkg::XLU_ST_OP;
                    end else if (byte_i[7:4] == xlu_pkg::XLU_EA_IND
                        || byte_i[7:4] == xlu_pkg::XLU_EA_PREDEC
                        || byte_i[7:4] == xlu_pkg::XLU_EA_POSTINC) begin
                        next_state = xlu_pkg::XLU_ST_OP;
                    end else if (byte_i[7:4] == xlu_pkg::XLU_EA_D8) begin
                        next_state = xlu_pkg::XLU_ST_EXT_L;
                    end else if (byte_i[7:4] == xlu_pkg::XLU_EA_D16) begin
                        next_state = xlu_pkg::XLU_ST_EXT_H;
                    end else if (byte_i[2:0] == xlu_pkg::XLU_EA_ABS_LOW
                        && byte_i[7:4] == xlu_pkg::XLU_EA_AA8) begin
                        next_state = xlu_pkg::XLU_ST_EXT_L;
                    end else if (byte_i[2:0] == xlu_pkg::XLU_EA_ABS_LOW
                        && byte_i[7:4] == xlu_pkg::XLU_EA_AA16) begin
                        next_state = xlu_pkg::XLU_ST_EXT_H;
                    end
                end
                xlu_pkg::XLU_ST_EXT_H: begin
                    next_insn.imm[15:8] = byte_i;
                    next_state = xlu_pkg::XLU_ST_EXT_L;
                end
                xlu_pkg::XLU_ST_EXT_L: begin
                    next_insn.imm[7:0] = byte_i;
                    next_state = xlu_pkg::XLU_ST_OP;
                end
                xlu_pkg::XLU_ST_OP: begin
                    next_state = xlu_pkg::XLU_ST_EA;
                end
                default: begin
                    next_state = xlu_pkg::XLU_ST_EA;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= xlu_pkg::XLU_ST_EA;
            insn <= '0;
        end else begin
            state <= next_state;
            insn <= next_insn;
        end
    end

    // ------------------------------------------------------------
    // Execution datapath
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] res;
        logic [7:0] res8;
        logic [2:0] csel;
        logic legal;
        src = 16'h0000;
        dst = 16'h0000;
        res = 16'h0000;
        res8 = 8'h00;
        csel = byte_i[2:0];
        legal = 1'b0;
        next_gr = gr;
        next_status_word = status_word;
        next_base_reg = base_reg;
        next_extended_page_reg = extended_page_reg;
        next_data_page_reg = data_page_reg;
        next_stack_page_reg = stack_page_reg;
        next_illegal_seen = illegal_seen;
        next_done = 1'b0;
        next_illegal = 1'b0;
        next_inhibit = 1'b0;

        // Software writes first; an instruction writeback in the same cycle wins
        if (bus_i.wr) begin
            if (!bus_i.addr[3]) begin
                next_gr[bus_i.addr[2:0]] = bus_i.wdata;
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_STATUS) begin
                next_status_word = bus_i.wdata;
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_BASE) begin
                next_base_reg = bus_i.wdata[7:0];
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_EXT) begin
                next_extended_page_reg = bus_i.wdata[7:0];
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_DATA) begin
                next_data_page_reg = bus_i.wdata[7:0];
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_STACK) begin
                next_stack_page_reg = bus_i.wdata[7:0];
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_UNIT) begin
                if (bus_i.wdata[xlu_pkg::XLU_UNIT_ILLEGAL]) begin
                    next_illegal_seen = 1'b0;
                end
            end
        end

        if (is_xor) begin
            // Source: register, immediate, or operand from the fetch unit
            if (insn.src_reg) begin
                src = gr[insn.rsel];
            end else if (insn.src_imm) begin
                src = insn.imm;
            end else begin
                src = operand_i;
            end
            dst = gr[byte_i[2:0]];
            res = dst ^ src;
            if (insn.word) begin
                next_gr[byte_i[2:0]] = res;
                next_status_word[xlu_pkg::XLU_FLAG_N] = res[15];
                next_status_word[xlu_pkg::XLU_FLAG_Z] = (res == 16'h0000);
            end else begin
                next_gr[byte_i[2:0]] = {dst[15:8], res[7:0]};
                next_status_word[xlu_pkg::XLU_FLAG_N] = res[7];
                next_status_word[xlu_pkg::XLU_FLAG_Z] = (res[7:0] == 8'h00);
            end
            next_status_word[xlu_pkg::XLU_FLAG_V] = 1'b0;
            next_done = 1'b1;
        end else if (is_ctrl) begin
            // Size must match the register, and only immediates are allowed
            if (!insn.src_imm) begin
                legal = 1'b0;
            end else if (csel == xlu_pkg::XLU_SEL_STATUS) begin
                legal = insn.word;
            end else begin
                legal = !insn.word && (csel == xlu_pkg::XLU_SEL_FLAGS
                    || csel == xlu_pkg::XLU_SEL_BASE || csel == xlu_pkg::XLU_SEL_EXT
                    || csel == xlu_pkg::XLU_SEL_DATA
                    || csel == xlu_pkg::XLU_SEL_STACK);
            end
            if (legal) begin
                unique case (csel)
                    xlu_pkg::XLU_SEL_STATUS: begin
                        next_status_word = status_word ^ insn.imm;
                    end
                    xlu_pkg::XLU_SEL_FLAGS: begin
                        next_status_word[7:0] = status_word[7:0] ^ insn.imm[7:0];
                    end
                    xlu_pkg::XLU_SEL_BASE: begin
                        res8 = base_reg ^ insn.imm[7:0];
                        next_base_reg = res8;
                    end
                    xlu_pkg::XLU_SEL_EXT: begin
                        res8 = extended_page_reg ^ insn.imm[7:0];
                        next_extended_page_reg = res8;
                    end
                    xlu_pkg::XLU_SEL_DATA: begin
                        res8 = data_page_reg ^ insn.imm[7:0];
                        next_data_page_reg = res8;
                    end
                    default: begin
                        res8 = stack_page_reg ^ insn.imm[7:0];
                        next_stack_page_reg = res8;
                    end
                endcase
                if (csel != xlu_pkg::XLU_SEL_STATUS && csel != xlu_pkg::XLU_SEL_FLAGS) begin
                    next_status_word[xlu_pkg::XLU_FLAG_N] = res8[7];
                    next_status_word[xlu_pkg::XLU_FLAG_Z] = (res8 == 8'h00);
                    next_status_word[xlu_pkg::XLU_FLAG_V] = 1'b0;
                end
                next_done = 1'b1;
                next_inhibit = 1'b1;
            end else begin
                // Disallowed combination: nothing is written, the event is flagged
                next_illegal = 1'b1;
                next_illegal_seen = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 8; i++) begin
                gr[i] <= xlu_pkg::XLU_RST_WORD;
            end
            status_word <= xlu_pkg::XLU_RST_WORD;
            base_reg <= xlu_pkg::XLU_RST_BYTE;
            extended_page_reg <= xlu_pkg::XLU_RST_BYTE;
            data_page_reg <= xlu_pkg::XLU_RST_BYTE;
            stack_page_reg <= xlu_pkg::XLU_RST_BYTE;
            illegal_seen <= 1'b0;
        end else begin
            gr <= next_gr;
            status_word <= next_status_word;
            base_reg <= next_base_reg;
            extended_page_reg <= next_extended_page_reg;
            data_page_reg <= next_data_page_reg;
            stack_page_reg <= next_stack_page_reg;
            illegal_seen <= next_illegal_seen;
        end
    end

    // ------------------------------------------------------------
    // Register read port and event outputs
    // ------------------------------------------------------------
    always_comb begin
        next_rd_data = 16'h0000;
        if (bus_i.rd) begin
            if (!bus_i.addr[3]) begin
                next_rd_data = gr[bus_i.addr[2:0]];
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_STATUS) begin
                next_rd_data = status_word;
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_BASE) begin
                next_rd_data = {8'h00, base_reg};
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_EXT) begin
                next_rd_data = {8'h00, extended_page_reg};
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_DATA) begin
                next_rd_data = {8'h00, data_page_reg};
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_STACK) begin
                next_rd_data = {8'h00, stack_page_reg};
            end else if (bus_i.addr == xlu_pkg::XLU_ADR_UNIT) begin
                next_rd_data = {10'h000, illegal_seen, int_inhibit_o, state};
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 16'h0000;
            done_o <= 1'b0;
            illegal_o <= 1'b0;
            int_inhibit_o <= 1'b0;
            trace_inhibit_o <= 1'b0;
        end else begin
            rd_data_o <= next_rd_data;
            done_o <= next_done;
            illegal_o <= next_illegal;
            int_inhibit_o <= next_inhibit;
            trace_inhibit_o <= next_inhibit;
        end
    end

endmodule

// ===== bench/xlu_top_checker.sv
// Checker of the exclusive-OR unit's completion and inhibit pulses
`timescale 1ns/1ps

module xlu_top_checker (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic [15:0] operand_i,
    input wire xlu_pkg::xlu_bus_s bus_i,
    input wire logic [15:0] rd_data_o,
    input wire logic done_o,
    input wire logic illegal_o,
    input wire logic int_inhibit_o,
    input wire logic trace_inhibit_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // ----------------------------------------
    // Control form: prefix, data, opcode
    // ----------------------------------------
    // Guard keeps a word form's high data byte from posing as a prefix
    sequence s_ctl(pfx, sel);
        byte_valid_i && byte_i == pfx && !$past(byte_valid_i && byte_i == 8'h0C)
        ##1 byte_valid_i
        ##1 byte_valid_i && byte_i == {xlu_pkg::XLU_OP_CTRL, sel};
    endsequence

    AST_INH_PAIR: assert property (int_inhibit_o == trace_inhibit_o)
        else $error("trace and interrupt inhibit differ");
    AST_INH_DONE: assert property (int_inhibit_o |-> done_o && !illegal_o)
        else $error("inhibit without completion");
    AST_EXCL: assert property (!(done_o && illegal_o))
        else $error("done and illegal together");
    AST_DONE_OP: assert property ((done_o || illegal_o) |-> $past(byte_valid_i) && $past(byte_i[7:4]) == 4'h6)
        else $error("completion without an opcode byte");
    AST_CTL_INH: assert property (done_o && $past(byte_i[7:3]) == xlu_pkg::XLU_OP_CTRL |-> int_inhibit_o)
        else $error("control form without inhibit");
    AST_REG_NOINH: assert property (done_o && $past(byte_i[7:3]) == xlu_pkg::XLU_OP_XOR |-> !int_inhibit_o)
        else $error("register form raised inhibit");
    AST_SEL_BAD: assert property (s_ctl(8'h04, 3'h2) |=> illegal_o && !done_o)
        else $error("selector 010 not refused");
    AST_SEL_STAT_B: assert property (s_ctl(8'h04, 3'h0) |=> illegal_o && !done_o)
        else $error("byte form on status word not refused");
    AST_SEL_BASE: assert property (s_ctl(8'h04, 3'h3) |=> done_o && int_inhibit_o)
        else $error("byte form on base register not executed");
    AST_DONE_GAP: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
endmodule

bind xlu_top xlu_top_checker chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .byte_valid_i(byte_valid_i), .byte_i(byte_i), .operand_i(operand_i), .bus_i(bus_i),
    .rd_data_o(rd_data_o), .done_o(done_o), .illegal_o(illegal_o),
    .int_inhibit_o(int_inhibit_o), .trace_inhibit_o(trace_inhibit_o));

// ===== bench/tb_xlu_top.sv
// Self-checking bench of the exclusive-OR unit
`timescale 1ns/1ps

module tb_xlu_top;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic byte_valid_i = 1'b0;
    logic [7:0] byte_i = 8'h00;
    logic [15:0] operand_i = 16'h0000;
    xlu_pkg::xlu_bus_s bus_i = '0;
    logic [15:0] rd_data_o;
    logic done_o;
    logic illegal_o;
    logic int_inhibit_o;
    logic trace_inhibit_o;
    logic [15:0] m [0:12];
    logic [15:0] exp_rd [$];
    logic [3:0] exp_ev [$];
    logic [3:0] ev;
    logic rd_seen = 1'b0;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'hA0629B2D;

    xlu_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .byte_valid_i(byte_valid_i),
        .byte_i(byte_i), .operand_i(operand_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
        .done_o(done_o), .illegal_o(illegal_o), .int_inhibit_o(int_inhibit_o),
        .trace_inhibit_o(trace_inhibit_o));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Verdict, compare and timeout
    // ----------------------------------------
    task give_verdict;
        if (exp_rd.size() + exp_ev.size() != 0) error_cnt++;
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    always @(posedge clk_i) begin
        rd_seen <= bus_i.rd;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // Oldest note is taken off whenever a result shows
    always @(negedge clk_i) begin
        ev = {done_o, illegal_o, int_inhibit_o, trace_inhibit_o};
        if (rd_seen && exp_rd.size() > 0) check("rd_data_o", exp_rd.pop_front(), rd_data_o);
        else if (!rd_seen) check("rd_data_o idle", 16'h0000, rd_data_o);
        if (ev !== 4'h0) check("events", exp_ev.size() > 0 ? exp_ev.pop_front() : 4'h0, ev);
    end

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    function automatic logic [15:0] rnd();
        return 16'($random(seed));
    endfunction

    // Idle byte lane shows the inverse of its last value
    task drive(input logic v, input logic [7:0] b, input logic [15:0] op,
               input xlu_pkg::xlu_bus_s bs);
        @(posedge clk_i);
        byte_valid_i <= v;
        byte_i <= v ? b : ~byte_i;
        operand_i <= op;
        bus_i <= bs;
    endtask

    task put(input logic [7:0] b, input logic [15:0] op);
        drive(1'b1, b, op, '0);
    endtask

    task bwr(input logic [3:0] a, input logic [15:0] d);
        drive(1'b0, 8'h00, rnd(), '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d});
    endtask

    task brd(input logic [3:0] a, input logic [15:0] e);
        exp_rd.push_back(e);
        drive(1'b0, 8'h00, rnd(), '{wr: 1'b0, rd: 1'b1, addr: a, wdata: rnd()});
    endtask

    function automatic logic [3:0] sel_adr(input logic [2:0] s);
        case (s)
            xlu_pkg::XLU_SEL_BASE: return xlu_pkg::XLU_ADR_BASE;
            xlu_pkg::XLU_SEL_EXT: return xlu_pkg::XLU_ADR_EXT;
            xlu_pkg::XLU_SEL_DATA: return xlu_pkg::XLU_ADR_DATA;
            xlu_pkg::XLU_SEL_STACK: return xlu_pkg::XLU_ADR_STACK;
            default: return xlu_pkg::XLU_ADR_STATUS;
        endcase
    endfunction

    task flags(input logic n, input logic z);
        m[8][3:0] = {n, z, 1'b0, m[8][0]};
    endtask

    task chk_reset;
        for (int a = 0; a < 13; a++) brd(4'(a), 16'h0000);
        brd(xlu_pkg::XLU_ADR_UNIT, 16'h0001);
        brd(4'hF, 16'h0000);
    endtask

    // ----------------------------------------
    // Register form in every addressing mode
    // ----------------------------------------
    task automatic xor_reg(input int md, input logic sz, input logic [2:0] rs,
                           input logic [2:0] rd, input logic [15:0] v);
        logic [7:0] ea;
        logic [15:0] s;
        logic [15:0] r;
        int ext;
        ext = 0;
        s = v;
        case (md)
            0: begin
                ea = {xlu_pkg::XLU_EA_RN, sz, rs};
                s = m[rs];
            end
            1: ea = {xlu_pkg::XLU_EA_IND, sz, rs};
            2: begin
                ea = {xlu_pkg::XLU_EA_D8, sz, rs};
                ext = 1;
            end
            3: begin
                ea = {xlu_pkg::XLU_EA_D16, sz, rs};
                ext = 2;
            end
            4: ea = {xlu_pkg::XLU_EA_PREDEC, sz, rs};
            5: ea = {xlu_pkg::XLU_EA_POSTINC, sz, rs};
            6: begin
                ea = {xlu_pkg::XLU_EA_AA8, sz, xlu_pkg::XLU_EA_ABS_LOW};
                ext = 1;
            end
            7: begin
                ea = {xlu_pkg::XLU_EA_AA16, sz, xlu_pkg::XLU_EA_ABS_LOW};
                ext = 2;
            end
            default: begin
                ea = sz ? xlu_pkg::XLU_PFX_IMM16 : xlu_pkg::XLU_PFX_IMM8;
                ext = sz ? 2 : 1;
            end
        endcase
        put(ea, rnd());
        for (int i = ext; i > 0; i--) put(md >= 8 ? (i == 2 ? v[15:8] : v[7:0]) : 8'(rnd()), rnd());
        put({xlu_pkg::XLU_OP_XOR, rd}, v);
        r = m[rd] ^ (sz ? s : {8'h00, s[7:0]});
        m[rd] = r;
        flags(sz ? r[15] : r[7], sz ? r == 16'h0000 : r[7:0] == 8'h00);
        exp_ev.push_back(4'h8);
        brd(4'(rd), m[rd]);
        brd(xlu_pkg::XLU_ADR_STATUS, m[8]);
    endtask

    // ----------------------------------------
    // Control form on every selector and size
    // ----------------------------------------
    task automatic xor_ctl(input logic [2:0] sel, input logic wd, input logic [15:0] v);
        logic [3:0] a;
        logic [7:0] r;
        logic ok;
        a = sel_adr(sel);
        ok = wd ? sel == xlu_pkg::XLU_SEL_STATUS : !(sel inside {3'h0, 3'h2, 3'h6});
        put(wd ? xlu_pkg::XLU_PFX_IMM16 : xlu_pkg::XLU_PFX_IMM8, rnd());
        if (wd) put(v[15:8], rnd());
        put(v[7:0], rnd());
        put({xlu_pkg::XLU_OP_CTRL, sel}, rnd());
        if (!ok) exp_ev.push_back(4'h4);
        else begin
            exp_ev.push_back(4'hB);
            if (sel == xlu_pkg::XLU_SEL_STATUS) m[8] = m[8] ^ v;
            else if (sel == xlu_pkg::XLU_SEL_FLAGS) m[8][7:0] = m[8][7:0] ^ v[7:0];
            else begin
                r = m[a][7:0] ^ v[7:0];
                m[a] = {8'h00, r};
                flags(r[7], r == 8'h00);
            end
        end
        brd(a, m[a]);
        if (a != xlu_pkg::XLU_ADR_STATUS) brd(xlu_pkg::XLU_ADR_STATUS, m[8]);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] v;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        chk_reset();
        for (int a = 0; a < 13; a++) begin
            v = rnd();
            bwr(4'(a), v);
            m[a] = a > 8 ? v & 16'h00FF : v;
        end
        bwr(4'hE, rnd());
        brd(4'hE, 16'h0000);
        for (int a = 0; a < 13; a++) brd(4'(a), m[a]);
        for (int s = 0; s < 8; s++) begin
            xor_ctl(3'(s), 1'b0, rnd());
            xor_ctl(3'(s), 1'b1, rnd());
        end
        put({xlu_pkg::XLU_EA_RN, 1'b0, 3'h1}, rnd());
        put({xlu_pkg::XLU_OP_CTRL, xlu_pkg::XLU_SEL_BASE}, rnd());
        exp_ev.push_back(4'h4);
        brd(xlu_pkg::XLU_ADR_BASE, m[9]);
        xor_reg(0, 1'b1, 3'h2, 3'h2, rnd());
        xor_reg(8, 1'b0, 3'h0, 3'h5, {8'h00, m[5][7:0] ^ 8'h80});
        for (int i = 0; i < 60; i++) xor_reg(i % 10, 1'(rnd()), 3'(rnd()), 3'(rnd()), rnd());
        repeat (3) drive(1'b0, 8'h00, rnd(), '0);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        chk_reset();
        repeat (3) drive(1'b0, 8'h00, rnd(), '0);
        give_verdict();
    end
endmodule
